// ===== verilog/sarsr_pkg.sv
// shared constants, states and helpers for the converter readout link
// assumes a 250 MHz system clock on both ends and a host-made serial clock
package sarsr_pkg;

   // ------------------------------------------------------------
   // clock and word layout
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_PS  = 4000;
   localparam int RESULT_W       = 14;
   localparam int SEL_W          = 3;
   localparam int TRAILER_W      = 2 * SEL_W;
   localparam int FRAME_BITS     = RESULT_W + TRAILER_W;
   localparam int EDGE_W         = 5;
   localparam int CNT_W          = 9;

   // ------------------------------------------------------------
   // timing, in ns (serial clock limit in MHz) as printed, then in clock cycles
   // ------------------------------------------------------------
   localparam int CONV_PGA_NS       = 1550;
   localparam int CONV_BYP_NS       = 660;
   localparam int BUSY_RISE_PGA_NS  = 100;
   localparam int BUSY_RISE_BYP_NS  = 30;
   localparam int CSH_NORM_NS       = 150;
   localparam int CSH_LPM_NS        = 500;
   localparam int SCK_MAX_MHZ       = 50;
   // longest times round down
   localparam int CONV_PGA_CYC      = CONV_PGA_NS * 1000 / CLK_PERIOD_PS;
   localparam int CONV_BYP_CYC      = CONV_BYP_NS * 1000 / CLK_PERIOD_PS;
   localparam int BUSY_RISE_PGA_CYC = BUSY_RISE_PGA_NS * 1000 / CLK_PERIOD_PS;
   localparam int BUSY_RISE_BYP_CYC = BUSY_RISE_BYP_NS * 1000 / CLK_PERIOD_PS;
   // least times round up
   localparam int CSH_NORM_CYC      = (CSH_NORM_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CSH_LPM_CYC       = (CSH_LPM_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SCK_MIN_PERIOD_PS = 1000000 / SCK_MAX_MHZ;
   localparam int SCK_HALF_CYC      = (SCK_MIN_PERIOD_PS + 2 * CLK_PERIOD_PS - 1) / (2 * CLK_PERIOD_PS);
   // covers device sync, output flop and host sync
   localparam int SDO_SETTLE_CYC    = 8;

   // ------------------------------------------------------------
   // states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      DEV_ACQ  = 2'h0,
      DEV_CONV = 2'h1,
      DEV_READ = 2'h3
   } sarsr_dev_state_t;

   typedef enum logic [2:0] {
      HST_IDLE    = 3'h0,
      HST_WAIT_HI = 3'h1,
      HST_WAIT_LO = 3'h3,
      HST_SETTLE  = 3'h2,
      HST_SCK_HI  = 3'h6
   } sarsr_host_state_t;

   function automatic logic [EDGE_W-1:0] sarsr_gray2bin(input logic [EDGE_W-1:0] g);
      logic [EDGE_W-1:0] b;
      b[EDGE_W-1] = g[EDGE_W-1];
      for (int i = EDGE_W - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

endpackage

// ===== verilog/sarsr_link_if.sv
// three-wire link between converter and host, plus busy
// assumes the host reads sdo only while the converter drives it
`timescale 1ns/1ps
interface sarsr_link_if;
   logic cs_n;
   logic sck;
   logic busy;
   logic sdo_drv;
   logic sdo_oe_n;
   wire  sdo;

   // no pull on the line: once released it shows the inverse of the last bit,
   // so a host that samples too late reads a wrong bit instead of a stale one
   assign sdo = sdo_drv ^ sdo_oe_n;

   modport dev (
      input  cs_n,
      input  sck,
      output busy,
      output sdo_drv,
      output sdo_oe_n
   );

   modport host (
      output cs_n,
      output sck,
      input  busy,
      input  sdo
   );
endinterface

// ===== verilog/sarsr_device_end.sv
// converter end: conversion sequencing, busy flag and serial readout
// assumes chip select and serial clock come from the host end of the link;
// the edge counter runs on the serial clock, everything else on clock_in
`timescale 1ns/1ps

module sarsr_device_end
   import sarsr_pkg::*;
#(
   parameter int CONV_PGA_CYCLES = CONV_PGA_CYC,
   parameter int CONV_BYP_CYCLES = CONV_BYP_CYC
) (
   // clock and reset
   input  wire logic                clock_in,
   input  wire logic                sys_rst_in,
   input  wire logic                clock_enable_in,
   // link
   sarsr_link_if.dev                lnk,
   // analog stand-in and select pins
   input  wire logic [RESULT_W-1:0] analog_sample_in,
   input  wire logic                channel_select_msb_in,
   input  wire logic                channel_select_mid_in,
   input  wire logic                channel_select_lsb_in,
   input  wire logic                gain_select_msb_in,
   input  wire logic                gain_select_mid_in,
   input  wire logic                gain_select_lsb_in,
   input  wire logic                pga_bypass_in,
   input  wire logic                low_power_mode_pin_in,
   input  wire logic                power_down_in,
   // status
   output logic                     post_conversion_doze_out,
   output logic                     result_invalid_out
);

   // ------------------------------------------------------------
   // serial clock domain: rising edges since select fell
   // ------------------------------------------------------------
   logic [EDGE_W-1:0] edge_bin_reg;
   logic [EDGE_W-1:0] edge_bin_next;
   logic [EDGE_W-1:0] edge_gray_reg;
   logic [EDGE_W-1:0] edge_gray_next;

   always_comb begin
      edge_bin_next = edge_bin_reg;
      if (edge_bin_reg < EDGE_W'(FRAME_BITS)) begin
         edge_bin_next = edge_bin_reg + 5'h01;
      end
      edge_gray_next = edge_bin_next ^ (edge_bin_next >> 1);
   end

   // the clock stops between frames, so select high clears the count
   always_ff @(posedge lnk.sck or posedge lnk.cs_n) begin
      if (lnk.cs_n) begin
         edge_bin_reg  <= 5'h00;
         edge_gray_reg <= 5'h00;
      end else begin
         edge_bin_reg  <= edge_bin_next;
         edge_gray_reg <= edge_gray_next;
      end
   end

   // ------------------------------------------------------------
   // crossings into clock_in
   // ------------------------------------------------------------
   logic              cs_n_s1_reg;
   logic              cs_n_s2_reg;
   logic              cs_n_d_reg;
   logic [EDGE_W-1:0] gray_s1_reg;
   logic [EDGE_W-1:0] gray_s2_reg;
   logic              cs_fall;
   logic              cs_rise;
   logic [EDGE_W-1:0] edge_cnt;

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         cs_n_s1_reg <= 1'h1;
         cs_n_s2_reg <= 1'h1;
         cs_n_d_reg  <= 1'h1;
         gray_s1_reg <= 5'h00;
         gray_s2_reg <= 5'h00;
      end else if (clock_enable_in) begin
         cs_n_s1_reg <= lnk.cs_n;
         cs_n_s2_reg <= cs_n_s1_reg;
         cs_n_d_reg  <= cs_n_s2_reg;
         gray_s1_reg <= edge_gray_reg;
         gray_s2_reg <= gray_s1_reg;
      end
   end

   assign cs_fall  = cs_n_d_reg & ~cs_n_s2_reg;
   assign cs_rise  = ~cs_n_d_reg & cs_n_s2_reg;
   assign edge_cnt = sarsr_gray2bin(gray_s2_reg);

   // ------------------------------------------------------------
   // conversion and readout sequencer
   // ------------------------------------------------------------
   sarsr_dev_state_t       state_reg;
   sarsr_dev_state_t       state_next;
   logic [CNT_W-1:0]       conv_cnt_reg;
   logic [CNT_W-1:0]       conv_cnt_next;
   logic [RESULT_W-1:0]    result_reg;
   logic [RESULT_W-1:0]    result_next;
   logic [TRAILER_W-1:0]   trailer_reg;
   logic [TRAILER_W-1:0]   trailer_next;
   logic [TRAILER_W-1:0]   sel_pipe1_reg;
   logic [TRAILER_W-1:0]   sel_pipe1_next;
   logic [TRAILER_W-1:0]   sel_pipe2_reg;
   logic [TRAILER_W-1:0]   sel_pipe2_next;
   logic                   busy_reg;
   logic                   busy_next;
   logic                   sdo_reg;
   logic                   sdo_next;
   logic                   sdo_oe_n_reg;
   logic                   sdo_oe_n_next;
   logic                   doze_reg;
   logic                   doze_next;
   logic                   warm_reg;
   logic                   warm_next;
   logic                   invalid_reg;
   logic                   invalid_next;
   logic [FRAME_BITS-1:0]  frame_word;
   logic [TRAILER_W-1:0]   sel_pins;
   logic                   frame_bit;

   assign sel_pins   = {channel_select_msb_in, channel_select_mid_in, channel_select_lsb_in,
                        gain_select_msb_in, gain_select_mid_in, gain_select_lsb_in};
   assign frame_word = {result_reg, trailer_reg};

   // past the last trailer bit the line just sits low
   assign frame_bit  = (edge_cnt < EDGE_W'(FRAME_BITS)) ?
                       frame_word[EDGE_W'(FRAME_BITS - 1) - edge_cnt] : 1'h0;

   always_comb begin
      state_next     = state_reg;
      conv_cnt_next  = conv_cnt_reg;
      result_next    = result_reg;
      trailer_next   = trailer_reg;
      sel_pipe1_next = sel_pipe1_reg;
      sel_pipe2_next = sel_pipe2_reg;
      busy_next      = busy_reg;
      sdo_next       = sdo_reg;
      sdo_oe_n_next  = sdo_oe_n_reg;
      doze_next      = doze_reg;
      warm_next      = warm_reg;
      invalid_next   = invalid_reg;

      // a wake pulse is needed before normal mode gives good data
      if (power_down_in) begin
         warm_next = 1'h0;
      end else if (cs_rise) begin
         warm_next = 1'h1;
      end

      if (cs_rise) begin
         sel_pipe1_next = sel_pins;
         sel_pipe2_next = sel_pipe1_reg;
      end

      case (state_reg)
         DEV_ACQ: begin
            busy_next     = 1'h0;
            sdo_oe_n_next = 1'h1;
            doze_next     = 1'h0;
            if (cs_fall) begin
               state_next    = DEV_CONV;
               result_next   = analog_sample_in;
               // low power applies this sample's selects, normal the previous
               trailer_next  = low_power_mode_pin_in ? sel_pipe1_reg : sel_pipe2_reg;
               conv_cnt_next = pga_bypass_in ? CNT_W'(CONV_BYP_CYCLES - 1) :
                                               CNT_W'(CONV_PGA_CYCLES - 1);
               busy_next     = 1'h1;
               sdo_next      = 1'h0;
               sdo_oe_n_next = 1'h0;
               invalid_next  = ~low_power_mode_pin_in & ~warm_reg;
            end
         end
         DEV_CONV: begin
            if (cs_rise) begin
               state_next    = DEV_ACQ;
               busy_next     = 1'h0;
               sdo_oe_n_next = 1'h1;
            end else if (conv_cnt_reg == 9'h000) begin
               state_next = DEV_READ;
               busy_next  = 1'h0;
               sdo_next   = result_reg[RESULT_W-1];
               doze_next  = 1'h1;
            end else begin
               conv_cnt_next = conv_cnt_reg - 9'h001;
            end
         end
         DEV_READ: begin
            sdo_next = frame_bit;
            if (cs_rise) begin
               // acquisition starts here, with full power back
               state_next    = DEV_ACQ;
               sdo_oe_n_next = 1'h1;
               doze_next     = 1'h0;
            end
         end
         default: begin
            state_next    = DEV_ACQ;
            busy_next     = 1'h0;
            sdo_oe_n_next = 1'h1;
            doze_next     = 1'h0;
         end
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         state_reg     <= DEV_ACQ;
         conv_cnt_reg  <= 9'h000;
         result_reg    <= 14'h0000;
         trailer_reg   <= 6'h00;
         sel_pipe1_reg <= 6'h00;
         sel_pipe2_reg <= 6'h00;
         busy_reg      <= 1'h0;
         sdo_reg       <= 1'h0;
         sdo_oe_n_reg  <= 1'h1;
         doze_reg      <= 1'h0;
         warm_reg      <= 1'h0;
         invalid_reg   <= 1'h0;
      end else if (clock_enable_in) begin
         state_reg     <= state_next;
         conv_cnt_reg  <= conv_cnt_next;
         result_reg    <= result_next;
         trailer_reg   <= trailer_next;
         sel_pipe1_reg <= sel_pipe1_next;
         sel_pipe2_reg <= sel_pipe2_next;
         busy_reg      <= busy_next;
         sdo_reg       <= sdo_next;
         sdo_oe_n_reg  <= sdo_oe_n_next;
         doze_reg      <= doze_next;
         warm_reg      <= warm_next;
         invalid_reg   <= invalid_next;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign lnk.busy                 = busy_reg;
   assign lnk.sdo_drv              = sdo_reg;
   assign lnk.sdo_oe_n             = sdo_oe_n_reg;
   assign post_conversion_doze_out = doze_reg;
   assign result_invalid_out       = invalid_reg;

endmodule // sarsr_device_end

// ===== verilog/sarsr_host_end.sv
// host end: drives select and a divided serial clock, collects results
// assumes the converter end answers on busy and the shared data line
`timescale 1ns/1ps
module sarsr_host_end
   import sarsr_pkg::*;
(
   // clock and reset
   input  wire logic                 clock_in,
   input  wire logic                 sys_rst_in,
   input  wire logic                 clock_enable_in,
   // link
   sarsr_link_if.host                lnk,
   // requests
   input  wire logic                 start_in,
   input  wire logic                 read_trailer_in,
   input  wire logic                 low_power_mode_in,
   // answers
   output logic                      ready_out,
   output logic                      result_valid_out,
   output logic                      result_discard_out,
   output logic [RESULT_W-1:0]       result_out,
   output logic [TRAILER_W-1:0]      trailer_out
);

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   logic busy_s1_reg;
   logic busy_s2_reg;
   logic sdo_s1_reg;
   logic sdo_s2_reg;

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         busy_s1_reg <= 1'h0;
         busy_s2_reg <= 1'h0;
         sdo_s1_reg  <= 1'h0;
         sdo_s2_reg  <= 1'h0;
      end else if (clock_enable_in) begin
         busy_s1_reg <= lnk.busy;
         busy_s2_reg <= busy_s1_reg;
         sdo_s1_reg  <= lnk.sdo;
         sdo_s2_reg  <= sdo_s1_reg;
      end
   end

   // ------------------------------------------------------------
   // frame sequencer
   // ------------------------------------------------------------
   sarsr_host_state_t      state_reg;
   sarsr_host_state_t      state_next;
   logic [CNT_W-1:0]       cnt_reg;
   logic [CNT_W-1:0]       cnt_next;
   logic [EDGE_W-1:0]      bit_reg;
   logic [EDGE_W-1:0]      bit_next;
   logic [FRAME_BITS-1:0]  shift_reg;
   logic [FRAME_BITS-1:0]  shift_next;
   logic                   trl_reg;
   logic                   trl_next;
   logic                   lpm_reg;
   logic                   lpm_next;
   logic                   warm_reg;
   logic                   warm_next;
   logic                   cs_n_reg;
   logic                   cs_n_next;
   logic                   sck_reg;
   logic                   sck_next;
   logic                   ready_reg;
   logic                   ready_next;
   logic                   valid_reg;
   logic                   valid_next;
   logic                   discard_reg;
   logic                   discard_next;
   logic [RESULT_W-1:0]    result_reg;
   logic [RESULT_W-1:0]    result_next;
   logic [TRAILER_W-1:0]   trailer_reg;
   logic [TRAILER_W-1:0]   trailer_next;
   logic [CNT_W-1:0]       csh_need;
   logic [EDGE_W-1:0]      last_bit;

   assign csh_need = low_power_mode_in ? CNT_W'(CSH_LPM_CYC) : CNT_W'(CSH_NORM_CYC);
   assign last_bit = trl_reg ? EDGE_W'(FRAME_BITS - 1) : EDGE_W'(RESULT_W - 1);

   always_comb begin
      state_next   = state_reg;
      cnt_next     = cnt_reg;
      bit_next     = bit_reg;
      shift_next   = shift_reg;
      trl_next     = trl_reg;
      lpm_next     = lpm_reg;
      warm_next    = warm_reg;
      cs_n_next    = cs_n_reg;
      sck_next     = sck_reg;
      valid_next   = 1'h0;
      discard_next = discard_reg;
      result_next  = result_reg;
      trailer_next = trailer_reg;

      case (state_reg)
         HST_IDLE: begin
            if (cnt_reg != 9'h1FF) begin
               cnt_next = cnt_reg + 9'h001;
            end
            if (start_in && cnt_reg >= csh_need) begin
               state_next = HST_WAIT_HI;
               cs_n_next  = 1'h0;
               trl_next   = read_trailer_in;
               lpm_next   = low_power_mode_in;
            end
         end
         HST_WAIT_HI: begin
            if (busy_s2_reg) begin
               state_next = HST_WAIT_LO;
            end
         end
         HST_WAIT_LO: begin
            // serial clock stays low the whole time busy is up
            if (!busy_s2_reg) begin
               state_next = HST_SETTLE;
               cnt_next   = 9'h000;
               bit_next   = 5'h00;
            end
         end
         HST_SETTLE: begin
            cnt_next = cnt_reg + 9'h001;
            if (cnt_reg == CNT_W'(SDO_SETTLE_CYC - 1)) begin
               shift_next = {shift_reg[FRAME_BITS-2:0], sdo_s2_reg};
               cnt_next   = 9'h000;
               if (bit_reg == last_bit) begin
                  // select rises a settle time after the last edge, not on it:
                  // simpler than aligning, costs a little throughput
                  state_next   = HST_IDLE;
                  cs_n_next    = 1'h1;
                  valid_next   = 1'h1;
                  discard_next = ~lpm_reg & ~warm_reg;
                  warm_next    = 1'h1;
                  result_next  = trl_reg ? shift_next[FRAME_BITS-1:TRAILER_W] : shift_next[RESULT_W-1:0];
                  trailer_next = trl_reg ? shift_next[TRAILER_W-1:0] : 6'h00;
               end else begin
                  state_next = HST_SCK_HI;
                  sck_next   = 1'h1;
                  bit_next   = bit_reg + 5'h01;
               end
            end
         end
         HST_SCK_HI: begin
            cnt_next = cnt_reg + 9'h001;
            if (cnt_reg == CNT_W'(SCK_HALF_CYC - 1)) begin
               state_next = HST_SETTLE;
               sck_next   = 1'h0;
               cnt_next   = 9'h000;
            end
         end
         default: begin
            state_next = HST_IDLE;
            cs_n_next  = 1'h1;
            sck_next   = 1'h0;
            cnt_next   = 9'h000;
         end
      endcase

      ready_next = (state_next == HST_IDLE) && (cnt_next >= csh_need);
   end

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         state_reg   <= HST_IDLE;
         cnt_reg     <= 9'h000;
         bit_reg     <= 5'h00;
         shift_reg   <= 20'h00000;
         trl_reg     <= 1'h0;
         lpm_reg     <= 1'h0;
         warm_reg    <= 1'h0;
         cs_n_reg    <= 1'h1;
         sck_reg     <= 1'h0;
         ready_reg   <= 1'h0;
         valid_reg   <= 1'h0;
         discard_reg <= 1'h0;
         result_reg  <= 14'h0000;
         trailer_reg <= 6'h00;
      end else if (clock_enable_in) begin
         state_reg   <= state_next;
         cnt_reg     <= cnt_next;
         bit_reg     <= bit_next;
         shift_reg   <= shift_next;
         trl_reg     <= trl_next;
         lpm_reg     <= lpm_next;
         warm_reg    <= warm_next;
         cs_n_reg    <= cs_n_next;
         sck_reg     <= sck_next;
         ready_reg   <= ready_next;
         valid_reg   <= valid_next;
         discard_reg <= discard_next;
         result_reg  <= result_next;
         trailer_reg <= trailer_next;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign lnk.cs_n           = cs_n_reg;
   assign lnk.sck            = sck_reg;
   assign ready_out          = ready_reg;
   assign result_valid_out   = valid_reg;
   assign result_discard_out = discard_reg;
   assign result_out         = result_reg;
   assign trailer_out        = trailer_reg;

endmodule // sarsr_host_end

// ===== verif/sarsr_link_assertions.sv
// link checker: timing seen on the shared wires
// assumes both ends run on clock_in with a sync active-high reset
`timescale 1ns/1ps
module sarsr_link_assertions (
   // clock and reset
   input wire logic clock_in,
   input wire logic sys_rst_in,
   // link wires
   input wire logic cs_n,
   input wire logic sck,
   input wire logic busy,
   input wire logic sdo_drv,
   input wire logic sdo_oe_n
);
   logic [5:0] hi_reg;
   logic [5:0] hi_next;
   // saturates, so only the normal-mode minimum is checked
   always_comb hi_next = cs_n ? hi_reg + {5'h00, hi_reg != 6'h3F} : 6'h00;
   always_ff @(posedge clock_in) hi_reg <= sys_rst_in ? 6'h00 : hi_next;
   // ----------------
   // properties
   // ----------------
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);
   sdo_released_a: assert property (cs_n [*5] |-> sdo_oe_n) else $error("sdo driven");
   drive_low_a: assert property ($fell(cs_n) |-> ##[1:7] (!sdo_oe_n && !sdo_drv)) else $error("no low");
   busy_rise_a: assert property ($fell(cs_n) |-> ##[1:7] busy) else $error("busy late");
   busy_hold_a: assert property ($rose(busy) |-> busy [*8]) else $error("busy short");
   conv_end_a: assert property ($rose(busy) |-> ##[1:387] !busy) else $error("conv long");
   msb_ready_a: assert property ($fell(busy) && !cs_n |-> !sdo_oe_n) else $error("msb absent");
   sck_quiet_a: assert property (busy |-> !sck) else $error("sck in conv");
   sck_rate_a: assert property ($rose(sck) |-> sck [*3]) else $error("sck fast");
   select_gap_a: assert property ($fell(cs_n) |-> hi_reg >= 6'h26) else $error("cs gap");
   abort_release_a: assert property ($rose(cs_n) |-> ##[1:5] (sdo_oe_n && !busy)) else $error("no release");
endmodule // sarsr_link_assertions

// ===== verif/tb.sv
// bench: host end and device end joined by the link
// assumes a shared clock_in; the host end makes the serial clock
`timescale 1ns/1ps
module tb
   import sarsr_pkg::*;
;
   logic                clock_in   = 1'b0;
   logic                sys_rst_in = 1'b1;
   logic                start      = 1'b0;
   logic                trl        = 1'b0;
   logic                low_power_mode_pin        = 1'b0;
   logic                byp        = 1'b0;
   logic                pdn        = 1'b0;
   logic [5:0]          lat1       = 6'h00;
   logic [5:0]          lat2       = 6'h00;
   logic                ready;
   logic                valid;
   logic [RESULT_W-1:0] sample     = 14'h0000;
   logic [5:0]          sel        = 6'h00;
   wire  [22:0]         got;
   logic [22:0]         exp_q[$];
   int                  mismatches = 0;
   int                  tests_run  = 0;
   int                  cycles     = 0;
   int                  seed       = 28;

   sarsr_link_if sarsr_link_if_i ();
   // short conversions keep the run brief
   sarsr_device_end #(.CONV_PGA_CYCLES(20), .CONV_BYP_CYCLES(10)) sarsr_device_end_i (
      .clock_in(clock_in), .sys_rst_in(sys_rst_in), .clock_enable_in(1'b1), .lnk(sarsr_link_if_i.dev),
      .analog_sample_in(sample), .channel_select_msb_in(sel[5]), .channel_select_mid_in(sel[4]),
      .channel_select_lsb_in(sel[3]), .gain_select_msb_in(sel[2]), .gain_select_mid_in(sel[1]),
      .gain_select_lsb_in(sel[0]), .pga_bypass_in(byp), .low_power_mode_pin_in(low_power_mode_pin), .power_down_in(pdn),
      .post_conversion_doze_out(got[22]), .result_invalid_out(got[21]));
   sarsr_host_end sarsr_host_end_i (
      .clock_in(clock_in), .sys_rst_in(sys_rst_in), .clock_enable_in(1'b1), .lnk(sarsr_link_if_i.host),
      .start_in(start), .read_trailer_in(trl), .low_power_mode_in(low_power_mode_pin), .ready_out(ready),
      .result_valid_out(valid), .result_discard_out(got[20]), .result_out(got[19:6]), .trailer_out(got[5:0]));
   sarsr_link_assertions sarsr_link_assertions_i (
      .clock_in(clock_in), .sys_rst_in(sys_rst_in), .cs_n(sarsr_link_if_i.cs_n), .sck(sarsr_link_if_i.sck),
      .busy(sarsr_link_if_i.busy), .sdo_drv(sarsr_link_if_i.sdo_drv), .sdo_oe_n(sarsr_link_if_i.sdo_oe_n));

   initial forever #2 clock_in = ~clock_in;

   task automatic complete_run();
      if (mismatches == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic check_frame(input logic [22:0] g, input logic [22:0] w);
      tests_run++;
      if (g !== w) begin
         mismatches++;
         $display("MISMATCH %0t got %h want %h", $time, g, w);
      end
   endtask

   // ----------------
   // one frame; selects change every frame
   // ----------------
   task automatic frame(input logic l, input logic t, input logic p, input int n);
      logic [RESULT_W-1:0] s;
      logic [5:0]          c;
      s = RESULT_W'($random(seed));
      c = 6'($random(seed));
      while (ready !== 1'b1) @(posedge clock_in);
      // last frame is over; mode change moves the select-high minimum,
      // so ready is looked at again only once it reflects the new mode
      sel    <= c;
      sample <= s;
      low_power_mode_pin    <= l;
      trl    <= t;
      pdn    <= p;
      byp    <= 1'($random(seed));
      repeat (2) @(posedge clock_in);
      pdn    <= 1'b0;
      while (ready !== 1'b1) @(posedge clock_in);
      start <= 1'b1;
      @(posedge clock_in);
      start <= 1'b0;
      // low power applies selects latched at the last rise, normal the one before
      exp_q.push_back({1'b1, ~l & (n == 0 || p), n == 0, s, t ? (l ? lat1 : lat2) : 6'h00});
      lat2 = lat1;
      lat1 = c;
      @(posedge clock_in);
   endtask

   always @(posedge clock_in) begin
      cycles <= cycles + 1;
      if (valid === 1'b1) check_frame(got, exp_q.size() > 0 ? exp_q.pop_front() : 23'h0);
      if (cycles == 20000) begin
         mismatches++;
         complete_run();
      end
   end

   initial begin
      repeat (4) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      for (int n = 0; n < 18; n++) begin
         frame(n > 2 ? 1'($random(seed)) : 1'b0, n % 2 == 1 ? 1'b1 : 1'($random(seed)), n % 6 == 4, n);
      end
      while (exp_q.size() > 0) @(posedge clock_in);
      complete_run();
   end
endmodule // tb
